/* hw/ssoe_regs.sv */
// Operation
// - reference-present status reads 1 while a reference reaches the first loop
// - forced-midrail status reads 1 while the control voltage is forced
// - two-bit indicator reports the input actually selected, 00 to 11
// - periodic pulse ready status reads 1 once repeating pulse mode is initialised
// - writing pulse generator setting 111 stops continuous pulse generation
// - writing 1 to bit 7 at pll1_relock_strobe_reg fires a self-clearing relock strobe
// - writing 1 to bit 7 at divider_sync_strobe_reg fires a self-clearing divider sync strobe
// - writing 1 to bit 7 at pulse_launch_strobe_reg fires a self-clearing pulse launch strobe
// - output enables reset to 0; 1 enables the output
// - a disabled output stays at static low, except C and D outputs driven by an external oscillator
// - disabled C and D outputs sit high when driven by an external oscillator
// - loss latch records any reference loss until host clears it, set wins
`timescale 1ns/10ps
`include "ssoe_consts.svh"

module ssoe_regs
  import ssoe_pkg::*;
#(
  parameter int OUT_COUNT = `SSOE_OUT_COUNT
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic regRvalid,
  input wire logic refPresent,
  input wire logic vcForced,
  input wire logic [1:0] activeInput,
  input wire logic periodicPulseReady,
  input wire logic [2:0] pulseGeneratorSetting,
  input wire logic pulseSettingWrite,
  input wire logic lossLatchClear,
  input wire logic extOscChoiceC,
  input wire logic extOscChoiceD,
  input wire logic [OUT_COUNT-1:0] srcClk,
  output logic [OUT_COUNT-1:0] qOut,
  output logic relockPulse,
  output logic divSyncPulse,
  output logic pulseLaunch,
  output logic pulseStop,
  output logic statusRefPresent,
  output logic statusVcForced,
  output logic [1:0] statusActiveInput,
  output logic statusPulseReady,
  output logic refLossLatch
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic hitRelock;
  logic hitDivSync;
  logic hitLaunch;
  logic hitEnLow;
  logic hitEnMid;
  logic hitEnHigh;
  logic strobeBit;
  logic [`SSOE_STROBE_COUNT-1:0] strobeFire;
  logic [`SSOE_STROBE_COUNT-1:0] strobeOut;

  assign hitRelock = regAddr == `SSOE_ADDR_RELOCK;
  assign hitDivSync = regAddr == `SSOE_ADDR_DIVSYNC;
  assign hitLaunch = regAddr == `SSOE_ADDR_LAUNCH;
  assign hitEnLow = regAddr == `SSOE_ADDR_EN_LOW;
  assign hitEnMid = regAddr == `SSOE_ADDR_EN_MID;
  assign hitEnHigh = regAddr == `SSOE_ADDR_EN_HIGH;
  assign strobeBit = regWdata[`SSOE_STROBE_BIT];

  assign strobeFire[SSOE_STB_RELOCK] = regWrite && hitRelock && strobeBit;
  assign strobeFire[SSOE_STB_DIVSYNC] = regWrite && hitDivSync && strobeBit;
  assign strobeFire[SSOE_STB_LAUNCH] = regWrite && hitLaunch && strobeBit;

  ////////////////////////////////////////////////////////////////////////////
  // self-clearing strobes

  genvar s;
  generate
    for (s = 0; s < `SSOE_STROBE_COUNT; s++) begin : gStrobe
      ssoe_strobe_pulse uStrobe (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .fire(strobeFire[s]),
        .pulse(strobeOut[s])
      );
    end
  endgenerate

  assign relockPulse = strobeOut[SSOE_STB_RELOCK];
  assign divSyncPulse = strobeOut[SSOE_STB_DIVSYNC];
  assign pulseLaunch = strobeOut[SSOE_STB_LAUNCH];

  ////////////////////////////////////////////////////////////////////////////
  // output enable registers

  ssoe_byte_t enLow_reg;
  ssoe_byte_t enMid_reg;
  logic enHigh_reg;
  ssoe_byte_t enLow_next;
  ssoe_byte_t enMid_next;
  logic enHigh_next;
  logic [OUT_COUNT-1:0] enVec;
  logic [OUT_COUNT-1:0] idleLevel;
  logic [OUT_COUNT-1:0] qOut_reg;
  logic [OUT_COUNT-1:0] qOut_next;

  assign enLow_next = (regWrite && hitEnLow) ? regWdata : enLow_reg;
  assign enMid_next = (regWrite && hitEnMid) ? regWdata : enMid_reg;
  // only bit 0 of the high byte is stored
  assign enHigh_next = (regWrite && hitEnHigh) ? regWdata[0] : enHigh_reg;
  assign enVec = {enHigh_reg, enMid_reg, enLow_reg};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enLow_reg <= `SSOE_EN_RESET;
      enMid_reg <= `SSOE_EN_RESET;
      enHigh_reg <= 1'b0;
    end else begin
      enLow_reg <= enLow_next;
      enMid_reg <= enMid_next;
      enHigh_reg <= enHigh_next;
    end
  end

  genvar o;
  generate
    for (o = 0; o < OUT_COUNT; o++) begin : gOut
      if (o == `SSOE_IDX_QC0 || o == `SSOE_IDX_QC1) begin : gC
        assign idleLevel[o] = extOscChoiceC;
      end else if (o == `SSOE_IDX_QD0 || o == `SSOE_IDX_QD1) begin : gD
        assign idleLevel[o] = extOscChoiceD;
      end else begin : gPlain
        assign idleLevel[o] = 1'b0;
      end
      assign qOut_next[o] = enVec[o] ? srcClk[o] : idleLevel[o];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      qOut_reg <= '0;
    end else begin
      qOut_reg <= qOut_next;
    end
  end

  assign qOut = qOut_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  ssoe_byte_t rdSel;
  ssoe_byte_t regRdata_reg;
  logic regRvalid_reg;

  // strobe registers are write-only and read as zero
  assign rdSel = hitEnLow ? enLow_reg :
                 hitEnMid ? enMid_reg :
                 hitEnHigh ? {7'h00, enHigh_reg} :
                 `SSOE_READ_ZERO;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_reg <= `SSOE_READ_ZERO;
      regRvalid_reg <= 1'b0;
    end else begin
      regRdata_reg <= regRead ? rdSel : regRdata_reg;
      regRvalid_reg <= regRead;
    end
  end

  assign regRdata = regRdata_reg;
  assign regRvalid = regRvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status flags, loss latch and pulse stop

  logic statRef_reg;
  logic statVc_reg;
  logic [1:0] statSel_reg;
  logic statReady_reg;
  logic lossLatch_reg;
  logic lossLatch_next;
  logic pulseStop_reg;
  logic stopHit;

  // a loss in the clearing cycle keeps the latch set
  assign lossLatch_next = !refPresent ? 1'b1 : (lossLatchClear ? 1'b0 : lossLatch_reg);
  assign stopHit = pulseSettingWrite && (pulseGeneratorSetting == `SSOE_SETTING_STOP);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      statRef_reg <= 1'b0;
      statVc_reg <= 1'b0;
      statSel_reg <= 2'h0;
      statReady_reg <= 1'b0;
      lossLatch_reg <= 1'b0;
      pulseStop_reg <= 1'b0;
    end else begin
      statRef_reg <= refPresent;
      statVc_reg <= vcForced;
      statSel_reg <= activeInput;
      statReady_reg <= periodicPulseReady;
      lossLatch_reg <= lossLatch_next;
      pulseStop_reg <= stopHit;
    end
  end

  assign statusRefPresent = statRef_reg;
  assign statusVcForced = statVc_reg;
  assign statusActiveInput = statSel_reg;
  assign statusPulseReady = statReady_reg;
  assign refLossLatch = lossLatch_reg;
  assign pulseStop = pulseStop_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_relock;
    @(posedge ref_clk) disable iff (!nrst)
    (regWrite && regAddr == `SSOE_ADDR_RELOCK && regWdata[`SSOE_STROBE_BIT]) |=> relockPulse;
  endproperty
  a_relock: assert property (p_relock) else $error("relock strobe missing");

  property p_relock_quiet;
    @(posedge ref_clk) disable iff (!nrst)
    !(regWrite && regAddr == `SSOE_ADDR_RELOCK && regWdata[`SSOE_STROBE_BIT]) |=> !relockPulse;
  endproperty
  a_relock_quiet: assert property (p_relock_quiet) else $error("relock strobe without write");

  property p_divsync;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(divSyncPulse) |-> $past(regWrite && regAddr == `SSOE_ADDR_DIVSYNC && regWdata[`SSOE_STROBE_BIT]);
  endproperty
  a_divsync: assert property (p_divsync) else $error("divider sync strobe without cause");

  property p_launch;
    @(posedge ref_clk) disable iff (!nrst)
    (regWrite && regAddr == `SSOE_ADDR_LAUNCH && regWdata[`SSOE_STROBE_BIT]) |=> pulseLaunch;
  endproperty
  a_launch: assert property (p_launch) else $error("pulse launch strobe missing");

  property p_stop;
    @(posedge ref_clk) disable iff (!nrst)
    pulseStop |-> $past(pulseSettingWrite) && $past(pulseGeneratorSetting) == `SSOE_SETTING_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("pulse stop without setting 111");

  property p_enable_pass;
    @(posedge ref_clk) disable iff (!nrst)
    enVec[0] |=> qOut[0] == $past(srcClk[0]);
  endproperty
  a_enable_pass: assert property (p_enable_pass) else $error("enabled output does not follow source");

  property p_disabled_low;
    @(posedge ref_clk) disable iff (!nrst)
    (!enVec[0] && !enVec[8]) |=> !qOut[0] && !qOut[8];
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled output not low");

  property p_c_high;
    @(posedge ref_clk) disable iff (!nrst)
    (!enVec[4] && extOscChoiceC) |=> qOut[4];
  endproperty
  a_c_high: assert property (p_c_high) else $error("disabled C output not high");

  property p_d_high;
    @(posedge ref_clk) disable iff (!nrst)
    (!enVec[`SSOE_IDX_QD0] && extOscChoiceD) |=> qOut[`SSOE_IDX_QD0];
  endproperty
  a_d_high: assert property (p_d_high) else $error("disabled D output not high");

  property p_loss;
    @(posedge ref_clk) disable iff (!nrst)
    !refPresent |=> refLossLatch && !statusRefPresent;
  endproperty
  a_loss: assert property (p_loss) else $error("reference loss not latched");

  property p_reserved;
    @(posedge ref_clk) disable iff (!nrst)
    (regRead && regAddr == `SSOE_ADDR_EN_HIGH) |=> regRvalid && regRdata[7:1] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_status;
    @(posedge ref_clk) disable iff (!nrst)
    ##1 statusActiveInput == $past(activeInput) && statusVcForced == $past(vcForced);
  endproperty
  a_status: assert property (p_status) else $error("status flags lag or wrong");

  c_sync_then_launch: cover property (@(posedge ref_clk) disable iff (!nrst)
    divSyncPulse ##[1:20] pulseLaunch);
  c_relock: cover property (@(posedge ref_clk) disable iff (!nrst) relockPulse);
  c_loss_clear: cover property (@(posedge ref_clk) disable iff (!nrst)
    refLossLatch ##1 !refLossLatch);
  c_stop: cover property (@(posedge ref_clk) disable iff (!nrst) pulseStop);

endmodule

/* hw/ssoe_consts.svh */
`ifndef SSOE_CONSTS_SVH
`define SSOE_CONSTS_SVH

// register byte addresses on the serial control port
`define SSOE_ADDR_RELOCK 8'h98
`define SSOE_ADDR_DIVSYNC 8'h99
`define SSOE_ADDR_LAUNCH 8'h9b
`define SSOE_ADDR_EN_LOW 8'h9c
`define SSOE_ADDR_EN_MID 8'h9d
`define SSOE_ADDR_EN_HIGH 8'h9e

// strobe bit inside each synchronization register
`define SSOE_STROBE_BIT 7

// output enable layout
`define SSOE_OUT_COUNT 17
`define SSOE_EN_HIGH_WIDTH 1
`define SSOE_EN_RESET 8'h00
`define SSOE_IDX_QC0 4
`define SSOE_IDX_QC1 5
`define SSOE_IDX_QD0 6
`define SSOE_IDX_QD1 7

// pulse generator setting that ends continuous generation
`define SSOE_SETTING_STOP 3'h7

// number of self-clearing strobes
`define SSOE_STROBE_COUNT 3

// read data returned for write-only, reserved or unmapped bytes
`define SSOE_READ_ZERO 8'h00

`endif

/* hw/ssoe_pkg.sv */
package ssoe_pkg;

  typedef logic [7:0] ssoe_byte_t;

  typedef logic [2:0] ssoe_setting_t;

  // position of each strobe in the strobe vector
  typedef enum logic [1:0] {
    SSOE_STB_RELOCK = 2'h0,
    SSOE_STB_DIVSYNC = 2'h1,
    SSOE_STB_LAUNCH = 2'h2
  } ssoe_strobe_e;

endpackage

/* hw/ssoe_strobe_pulse.sv */
`timescale 1ns/10ps

module ssoe_strobe_pulse
  import ssoe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fire,
  output logic pulse
);

  logic pulse_reg;
  logic pulse_next;

  // one cycle high per accepted write, then clears on its own
  assign pulse_next = fire;
  assign pulse = pulse_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

endmodule

/* test/ssoe_host_model.sv */
`timescale 1ns/10ps
`include "ssoe_consts.svh"

module ssoe_host_model
  import ssoe_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  logic syncDone;

  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    syncDone = 1'b0;
  end

  task automatic put(input ssoe_byte_t addr, input ssoe_byte_t data, input logic isRead);
    @(posedge ref_clk);
    #1;
    regAddr = addr;
    regWdata = data;
    regWrite = ~isRead;
    regRead = isRead;
    @(posedge ref_clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    // released bus must not keep showing the last byte
    regAddr = ~regAddr;
    regWdata = ~regWdata;
  endtask

  task automatic wr(input ssoe_byte_t addr, input ssoe_byte_t data);
    logic needSync;
    needSync = data[`SSOE_STROBE_BIT] && (addr == `SSOE_ADDR_RELOCK || addr == `SSOE_ADDR_LAUNCH);
    if (needSync && !syncDone) begin
      put(`SSOE_ADDR_DIVSYNC, 8'h80, 1'b0);
      syncDone = 1'b1;
    end
    if (addr == `SSOE_ADDR_DIVSYNC && data[`SSOE_STROBE_BIT]) begin
      syncDone = 1'b1;
    end
    put(addr, data, 1'b0);
  endtask

  task automatic rd(input ssoe_byte_t addr, output ssoe_byte_t data, output logic valid);
    put(addr, 8'h00, 1'b1);
    data = regRdata;
    valid = regRvalid;
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/10ps
`include "ssoe_consts.svh"

module tb
  import ssoe_pkg::*;
;
  logic ref_clk, nrst, regWrite, regRead, regRvalid;
  logic [7:0] regAddr, regWdata, regRdata;
  logic refPresent, vcForced, periodicPulseReady, pulseSettingWrite, lossLatchClear;
  logic [1:0] activeInput, statusActiveInput;
  logic [2:0] pulseGeneratorSetting;
  logic extOscChoiceC, extOscChoiceD;
  logic [16:0] srcClk, qOut;
  logic relockPulse, divSyncPulse, pulseLaunch, pulseStop;
  logic statusRefPresent, statusVcForced, statusPulseReady, refLossLatch;
  int n_errors = 0;
  int checks_done = 0;
  ssoe_byte_t stbAddr [3] = '{`SSOE_ADDR_DIVSYNC, `SSOE_ADDR_RELOCK, `SSOE_ADDR_LAUNCH};
  ssoe_strobe_e stbKind [3] = '{SSOE_STB_DIVSYNC, SSOE_STB_RELOCK, SSOE_STB_LAUNCH};

  ssoe_regs #(.OUT_COUNT(`SSOE_OUT_COUNT)) u_ssoe_regs (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid),
    .refPresent(refPresent), .vcForced(vcForced), .activeInput(activeInput),
    .periodicPulseReady(periodicPulseReady), .pulseGeneratorSetting(pulseGeneratorSetting),
    .pulseSettingWrite(pulseSettingWrite), .lossLatchClear(lossLatchClear), .extOscChoiceC(extOscChoiceC),
    .extOscChoiceD(extOscChoiceD), .srcClk(srcClk), .qOut(qOut), .relockPulse(relockPulse),
    .divSyncPulse(divSyncPulse), .pulseLaunch(pulseLaunch), .pulseStop(pulseStop),
    .statusRefPresent(statusRefPresent), .statusVcForced(statusVcForced),
    .statusActiveInput(statusActiveInput), .statusPulseReady(statusPulseReady), .refLossLatch(refLossLatch));

  ssoe_host_model u_ssoe_host_model (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid));

  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input ssoe_byte_t addr, input ssoe_byte_t exp);
    ssoe_byte_t data;
    logic valid;
    u_ssoe_host_model.rd(addr, data, valid);
    chk("regRvalid", 32'h1, 32'(valid));
    chk("regRdata", 32'(exp), 32'(data));
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    {refPresent, vcForced, periodicPulseReady, pulseSettingWrite, lossLatchClear} = 5'h10;
    {activeInput, pulseGeneratorSetting, extOscChoiceC, extOscChoiceD} = 7'h00;
    srcClk = 17'h1ffff;
    repeat (5) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    tick();
    chk("qOut reset", 32'h0, 32'(qOut));
    rdchk(`SSOE_ADDR_EN_LOW, `SSOE_EN_RESET);
    rdchk(`SSOE_ADDR_EN_MID, `SSOE_EN_RESET);
    rdchk(`SSOE_ADDR_EN_HIGH, `SSOE_EN_RESET);
    for (int i = 0; i < 3; i++) begin
      u_ssoe_host_model.wr(stbAddr[i], 8'h7f);
      chk("strobe idle", 32'h0, 32'({pulseLaunch, divSyncPulse, relockPulse}));
      u_ssoe_host_model.wr(stbAddr[i], 8'h80);
      chk("strobe fire", 32'h1 << stbKind[i], 32'({pulseLaunch, divSyncPulse, relockPulse}));
      tick();
      chk("strobe clear", 32'h0, 32'({pulseLaunch, divSyncPulse, relockPulse}));
      rdchk(stbAddr[i], `SSOE_READ_ZERO);
    end
    u_ssoe_host_model.wr(8'h9f, 8'hff);
    rdchk(8'h9f, `SSOE_READ_ZERO);
    u_ssoe_host_model.wr(`SSOE_ADDR_EN_LOW, 8'hff);
    u_ssoe_host_model.wr(`SSOE_ADDR_EN_MID, 8'hff);
    u_ssoe_host_model.wr(`SSOE_ADDR_EN_HIGH, 8'hff);
    rdchk(`SSOE_ADDR_EN_LOW, 8'hff);
    rdchk(`SSOE_ADDR_EN_HIGH, 8'h01);
    chk("qOut enabled", 32'h1ffff, 32'(qOut));
    srcClk = 17'h0a5a5;
    tick();
    chk("qOut follows", 32'h0a5a5, 32'(qOut));
    for (int i = 1; i < 3; i++) begin
      {extOscChoiceD, extOscChoiceC} = 2'(i);
      u_ssoe_host_model.wr(`SSOE_ADDR_EN_LOW, 8'h00);
      u_ssoe_host_model.wr(`SSOE_ADDR_EN_MID, 8'h00);
      u_ssoe_host_model.wr(`SSOE_ADDR_EN_HIGH, 8'h00);
      tick();
      tick();
      chk("qOut idle", (i == 1) ? 32'h30 : 32'hc0, 32'(qOut));
    end
    for (int i = 0; i < 4; i++) begin
      refPresent = i[0];
      vcForced = ~i[0];
      periodicPulseReady = i[1];
      activeInput = 2'(i);
      tick();
      tick();
      chk("status", 32'({i[0], ~i[0], i[1], i[1:0]}),
        32'({statusRefPresent, statusVcForced, statusPulseReady, statusActiveInput}));
    end
    chk("loss latch set", 32'h1, 32'(refLossLatch));
    lossLatchClear = 1'b1;
    tick();
    lossLatchClear = 1'b0;
    tick();
    chk("loss latch clear", 32'h0, 32'(refLossLatch));
    {refPresent, lossLatchClear} = 2'h1;
    tick();
    {refPresent, lossLatchClear} = 2'h2;
    tick();
    chk("loss latch set wins", 32'h1, 32'(refLossLatch));
    for (int s = 0; s < 8; s++) begin
      pulseGeneratorSetting = 3'(s);
      pulseSettingWrite = 1'b1;
      tick();
      pulseSettingWrite = 1'b0;
      chk("pulseStop", 32'(3'(s) == `SSOE_SETTING_STOP), 32'(pulseStop));
      tick();
      chk("pulseStop end", 32'h0, 32'(pulseStop));
    end
    end_of_test();
  end
endmodule
